// [design/pmcc_clk_div.sv]
// Glitch-free programmable divider for the processor clock
`timescale 1ns/1ps
`default_nettype none
`include "pmcc_defines.svh"
module pmcc_clk_div #(
  parameter int RW = 6
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic tick,
  input wire logic run,
  input wire logic [RW-1:0] ratio,
  output logic clk_q,
  output logic rise_q,
  output logic stopped_q
);
  logic [RW-1:0] cnt_q;
  logic [RW-1:0] ratio_q;
  wire boundary = tick && ((cnt_q + RW'(1)) >= ratio_q);

  // New ratio is taken only at the start of a low phase, so a period is never cut short
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      cnt_q <= '0;
      ratio_q <= `PMCC_RAT_6144;
      clk_q <= 1'b1;
      rise_q <= 1'b0;
      stopped_q <= 1'b1;
    end else begin
      rise_q <= 1'b0;
      if (boundary) begin
        cnt_q <= '0;
        if (clk_q) begin
          stopped_q <= !run;
          if (run) begin
            clk_q <= 1'b0;
            ratio_q <= ratio;
          end
        end else begin
          clk_q <= 1'b1;
          rise_q <= 1'b1;
        end
      end else if (tick) begin
        cnt_q <= cnt_q + RW'(1);
      end
    end
  end

  clk_high_a: assert property (@(posedge clock) disable iff (!rst_n) stopped_q |-> clk_q)
    else $error("divider stopped with clock low");
endmodule // pmcc_clk_div
`default_nettype wire

// [design/pmcc_top.sv]
// Power-mode and processor-clock controller with AXI4-Lite registers
// Notes on behaviour
// - processor clock divided from crystal, seven rates
// - four power modes from mode field
// - active voice/data enables every block
// - data-only mode disables audio processor
// - idle after reset or idle code
// - idle keeps clock, host, line, hook interrupt
// - idle disables matrix, link, audio, port
// - serial outputs drive once matrix connected
// - entering idle clears link read-only registers
// - power-down stops clocks and oscillator
// - power-down only with enable bit set
// - count 250 clocks, then hold outputs high
// - interrupt during countdown cancels, clears mode
// - line busy keeps oscillator until F3
// - reset leaves power-down into idle
// - host chip select with write wakes, no data
// - hook change wakes when enabled
// - line F7 wakes; noise restops oscillator
// - port master wakes on serial data low
// - port slave wakes on serial clock high
// - wake resumes programmed rate without glitches
// - reset wake returns default 6.144 rate
// - two clocks before interrupt after wake
// - power-down code without enable means idle
// - interrupt low, 125us update, held until read
//
// The register offsets and the AXI4-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "pmcc_defines.svh"
module pmcc_top
  import pmcc_pkg::*;
#(
  parameter int INT_PERIOD_CYC = `PMCC_INT_PERIOD_NS / `PMCC_CLK_PERIOD_NS,
  parameter int AW = 8
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [AW-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [AW-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic crystal_in,
  output logic crystal_drive_out,
  output logic proc_clk_out,
  input wire logic host_cs_n,
  input wire logic host_wr_n,
  input wire logic hook_switch_in,
  input wire logic serial_data_in,
  input wire logic sclk_in,
  input wire logic [3:0] line_if_state,
  input wire logic irq_ext,
  input wire logic matrix_connected,
  output logic [7:0] block_enable,
  output logic link_ctrl_clear,
  output logic serial_drive_oe,
  output logic int_n
);
  localparam int TW = $clog2(INT_PERIOD_CYC + 1);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [5:0] sy1_q, sy2_q, sy3_q, filt_q;
  wire [5:0] pins = {sclk_in, serial_data_in, hook_switch_in, host_wr_n, host_cs_n, crystal_in};
  wire [5:0] agree = ~(sy2_q ^ sy3_q);
  wire [5:0] filt_d = (agree & sy2_q) | (~agree & filt_q);
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      sy1_q <= `PMCC_PIN_RST;
      sy2_q <= `PMCC_PIN_RST;
      sy3_q <= `PMCC_PIN_RST;
      filt_q <= `PMCC_PIN_RST;
    end else begin
      sy1_q <= pins;
      sy2_q <= sy1_q;
      sy3_q <= sy2_q;
      filt_q <= filt_d;
    end
  end

  // ----------------------------------------------------------------
  // Registers and state
  // ----------------------------------------------------------------
  pmcc_state_e st_q, st_d;
  logic [7:0] init_q, init_d, second_init_register_q, wcfg_q;
  logic [3:0] irq_q;
  logic second_init_register_arm_q, int_q, int_prev_q, li_f7_q, was_idle_q;
  logic [7:0] cd_cnt_q;
  logic [1:0] wake_cnt_q;
  logic [TW-1:0] tick_cnt_q;
  logic aw_q, w_q;
  logic [AW-1:0] awaddr_q;
  logic [7:0] wbyte_q;
  logic wlane_q;
  logic div_clk, div_rise, div_stopped;

  wire [1:0] mode = init_q[`PMCC_INIT_MODE];
  wire int_en = !init_q[`PMCC_INIT_INTDIS];
  wire pd_en = second_init_register_q[`PMCC_SECOND_INIT_REGISTER_PDEN];
  wire in_pd = (st_q == ST_PD) || (st_q == ST_PD_OSC);

  // ----------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------
  assign awready = !aw_q && !bvalid;
  assign wready = !w_q && !bvalid;
  assign arready = !rvalid;
  wire wr_do = aw_q && w_q;
  wire rd_do = arvalid && arready;
  wire wr_init = wr_do && wlane_q && (awaddr_q == `PMCC_OFS_INIT);
  wire wr_second_init_register = wr_do && wlane_q && (awaddr_q == `PMCC_OFS_SECOND_INIT_REGISTER);
  wire wr_wcfg = wr_do && wlane_q && (awaddr_q == `PMCC_OFS_WCFG);
  wire wr_map = (awaddr_q == `PMCC_OFS_INIT) || (awaddr_q == `PMCC_OFS_SECOND_INIT_REGISTER) ||
                (awaddr_q == `PMCC_OFS_WCFG) || (awaddr_q == `PMCC_OFS_IRQ) || (awaddr_q == `PMCC_OFS_STAT);
  wire ir_read = rd_do && (araddr == `PMCC_OFS_IRQ);
  wire [7:0] stat_byte = {3'h0, !div_stopped, int_q, st_q};
  wire rd_map = (araddr == `PMCC_OFS_INIT) || (araddr == `PMCC_OFS_SECOND_INIT_REGISTER) ||
                (araddr == `PMCC_OFS_WCFG) || (araddr == `PMCC_OFS_IRQ) || (araddr == `PMCC_OFS_STAT);
  wire [7:0] rd_byte = (araddr == `PMCC_OFS_INIT) ? init_q :
                       (araddr == `PMCC_OFS_SECOND_INIT_REGISTER) ? second_init_register_q :
                       (araddr == `PMCC_OFS_WCFG) ? wcfg_q :
                       (araddr == `PMCC_OFS_IRQ) ? {4'h0, irq_q} :
                       (araddr == `PMCC_OFS_STAT) ? stat_byte : 8'h00;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      aw_q <= 1'b0;
      w_q <= 1'b0;
      awaddr_q <= '0;
      wbyte_q <= 8'h00;
      wlane_q <= 1'b0;
      bvalid <= 1'b0;
      bresp <= `PMCC_RESP_OKAY;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= `PMCC_RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        aw_q <= 1'b1;
        awaddr_q <= awaddr;
      end
      if (wvalid && wready) begin
        w_q <= 1'b1;
        wbyte_q <= wdata[7:0];
        wlane_q <= wstrb[0];
      end
      if (wr_do) begin
        aw_q <= 1'b0;
        w_q <= 1'b0;
        bvalid <= 1'b1;
        bresp <= wr_map ? `PMCC_RESP_OKAY : `PMCC_RESP_SLVERR;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
      if (rd_do) begin
        rvalid <= 1'b1;
        rdata <= {24'h00_0000, rd_byte};
        rresp <= rd_map ? `PMCC_RESP_OKAY : `PMCC_RESP_SLVERR;
      end else if (rvalid && rready) begin
        rvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Wake and interrupt events
  // ----------------------------------------------------------------
  wire hook_chg = filt_d[`PMCC_PIN_HOOK] ^ filt_q[`PMCC_PIN_HOOK];
  wire sdi_fall = filt_q[`PMCC_PIN_SDI] && !filt_d[`PMCC_PIN_SDI];
  wire sclk_rise = !filt_q[`PMCC_PIN_SCLK] && filt_d[`PMCC_PIN_SCLK];
  wire li_at_f7 = (line_if_state == `PMCC_LI_F7);
  wire li_at_f3 = (line_if_state == `PMCC_LI_F3);
  wire line_en = wcfg_q[`PMCC_WCFG_LINE];
  wire ev_hook = hook_chg && wcfg_q[`PMCC_WCFG_HOOK];
  wire ev_f7 = li_at_f7 && !li_f7_q && wcfg_q[`PMCC_WCFG_F7];
  wire treq_edge = wcfg_q[`PMCC_WCFG_MASTER] ? sdi_fall : sclk_rise;
  wire ev_treq = treq_edge && wcfg_q[`PMCC_WCFG_TREQ];
  wire host_wake = !filt_q[`PMCC_PIN_CS] && !filt_q[`PMCC_PIN_WR];
  wire wake_any = host_wake || ev_hook || (int_en && (ev_f7 || ev_treq));
  wire wake_go = in_pd && wake_any;
  wire [3:0] irq_set = {irq_ext, ev_treq, ev_f7, ev_hook};
  wire int_tick = (tick_cnt_q == TW'(INT_PERIOD_CYC - 1));
  wire int_ok = int_en && !in_pd && (st_q != ST_WAKE);
  wire cancel = (st_q == ST_COUNT) && int_q && !int_prev_q;

  // Event set wins over a read clear in the same cycle
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      irq_q <= 4'h0;
      int_q <= 1'b0;
      int_prev_q <= 1'b0;
      tick_cnt_q <= '0;
      li_f7_q <= 1'b0;
    end else begin
      irq_q <= (ir_read ? 4'h0 : irq_q) | irq_set;
      tick_cnt_q <= int_tick ? '0 : tick_cnt_q + TW'(1);
      if (ir_read)
        int_q <= 1'b0;
      else if (int_tick && int_ok && (|irq_q))
        int_q <= 1'b1;
      int_prev_q <= int_q;
      li_f7_q <= li_at_f7;
    end
  end
  assign int_n = !int_q;

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  always_comb begin
    init_d = init_q;
    if (wr_init) begin
      init_d = wbyte_q;
      if (wbyte_q[`PMCC_INIT_MODE] == `PMCC_MODE_PD && !pd_en)
        init_d[`PMCC_INIT_MODE] = `PMCC_MODE_IDLE;
    end
    if (cancel || wake_go)
      init_d[`PMCC_INIT_MODE] = `PMCC_MODE_IDLE;
  end

  // Clock-stopping register needs two writes in a row; any other access disarms
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      init_q <= `PMCC_REG_RST;
      second_init_register_q <= `PMCC_REG_RST;
      wcfg_q <= `PMCC_REG_RST;
      second_init_register_arm_q <= 1'b0;
    end else begin
      init_q <= init_d;
      if (wr_wcfg)
        wcfg_q <= wbyte_q;
      if (wr_second_init_register && second_init_register_arm_q)
        second_init_register_q <= wbyte_q;
      if (wr_second_init_register)
        second_init_register_arm_q <= !second_init_register_arm_q;
      else if (wr_do || rd_do)
        second_init_register_arm_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Power-mode sequencer
  // ----------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    case (st_q)
      ST_RUN: begin
        if (mode == `PMCC_MODE_PD)
          st_d = ST_COUNT;
      end
      ST_COUNT: begin
        if (cancel)
          st_d = ST_RUN;
        else if (cd_cnt_q >= `PMCC_PD_COUNT)
          st_d = (line_en && !li_at_f3) ? ST_PD_OSC : ST_PD;
      end
      ST_PD_OSC: begin
        if (wake_go)
          st_d = ST_WAKE;
        else if (li_at_f3)
          st_d = ST_PD;
      end
      ST_PD: begin
        if (wake_go)
          st_d = ST_WAKE;
        else if (line_en && !li_at_f3)
          st_d = ST_PD_OSC;
      end
      ST_WAKE: begin
        if (wake_cnt_q >= `PMCC_WAKE_CLKS)
          st_d = ST_RUN;
      end
      default: st_d = ST_RUN;
    endcase
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      st_q <= ST_RUN;
      cd_cnt_q <= 8'h00;
      wake_cnt_q <= 2'h0;
    end else begin
      st_q <= st_d;
      cd_cnt_q <= (st_q != ST_COUNT) ? 8'h00 : cd_cnt_q + {7'h00, div_rise};
      if (st_q != ST_WAKE)
        wake_cnt_q <= 2'h0;
      else if (div_rise && wake_cnt_q != `PMCC_WAKE_CLKS)
        wake_cnt_q <= wake_cnt_q + 2'h1;
    end
  end

  // ----------------------------------------------------------------
  // Oscillator and processor clock
  // ----------------------------------------------------------------
  // The oscillator keeps running in full power-down until the divider has parked high
  wire osc_on = (st_q != ST_PD) || !div_stopped;
  wire xtal_tick = osc_on && (filt_d[`PMCC_PIN_XTAL] ^ filt_q[`PMCC_PIN_XTAL]);
  wire div_run = !in_pd && (second_init_register_q[`PMCC_SECOND_INIT_REGISTER_CLKSEL] != `PMCC_CK2_STOP);
  wire [2:0] ck1 = init_q[`PMCC_INIT_CLKSEL];
  wire [2:0] ck2 = second_init_register_q[`PMCC_SECOND_INIT_REGISTER_CLKSEL];
  wire [5:0] rat_init = (ck1 == `PMCC_CK1_12288) ? `PMCC_RAT_12288 :
                        (ck1 == `PMCC_CK1_3072) ? `PMCC_RAT_3072 :
                        (ck1 == `PMCC_CK1_4096) ? `PMCC_RAT_4096 : `PMCC_RAT_6144;
  wire [5:0] ratio = (ck2 == `PMCC_CK2_1536) ? `PMCC_RAT_1536 :
                     (ck2 == `PMCC_CK2_768) ? `PMCC_RAT_768 :
                     (ck2 == `PMCC_CK2_384) ? `PMCC_RAT_384 : rat_init;

  pmcc_clk_div #(.RW(6)) u_div (
    .clock(clock),
    .rst_n(rst_n),
    .tick(xtal_tick),
    .run(div_run),
    .ratio(ratio),
    .clk_q(div_clk),
    .rise_q(div_rise),
    .stopped_q(div_stopped)
  );
  assign proc_clk_out = div_clk;

  // ----------------------------------------------------------------
  // Block enables and side outputs
  // ----------------------------------------------------------------
  wire [7:0] en_mask = (st_q == ST_PD) ? `PMCC_EN_PD :
                       (st_q == ST_PD_OSC) ? `PMCC_EN_PDOSC :
                       (st_q != ST_RUN) ? `PMCC_EN_IDLE :
                       (mode == `PMCC_MODE_AVD) ? `PMCC_EN_FULL :
                       (mode == `PMCC_MODE_ADO) ? `PMCC_EN_DATA : `PMCC_EN_IDLE;
  wire idle_now = (st_q == ST_RUN) && (mode == `PMCC_MODE_IDLE);

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      block_enable <= `PMCC_EN_IDLE;
      link_ctrl_clear <= 1'b0;
      was_idle_q <= 1'b0;
      serial_drive_oe <= 1'b0;
      crystal_drive_out <= 1'b1;
    end else begin
      block_enable <= en_mask;
      was_idle_q <= idle_now;
      link_ctrl_clear <= idle_now && !was_idle_q;
      serial_drive_oe <= serial_drive_oe || matrix_connected;
      crystal_drive_out <= osc_on ? !filt_q[`PMCC_PIN_XTAL] : 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  pd_guard_a: assert property (@(posedge clock) disable iff (!rst_n)
    (st_q == ST_RUN && st_d == ST_COUNT) |-> pd_en)
    else $error("countdown started without power-down enable");
  count_min_a: assert property (@(posedge clock) disable iff (!rst_n)
    (st_q == ST_COUNT && (st_d == ST_PD || st_d == ST_PD_OSC)) |-> cd_cnt_q >= `PMCC_PD_COUNT)
    else $error("power-down entered before countdown ended");
  cancel_mode_a: assert property (@(posedge clock) disable iff (!rst_n)
    cancel |=> st_q == ST_RUN && mode == `PMCC_MODE_IDLE)
    else $error("interrupt did not cancel countdown");
  pd_high_a: assert property (@(posedge clock) disable iff (!rst_n)
    (st_q == ST_PD && div_stopped) [*2] |-> proc_clk_out && crystal_drive_out)
    else $error("outputs not held high in power-down");
  wake_int_a: assert property (@(posedge clock) disable iff (!rst_n)
    (st_q == ST_WAKE && st_d == ST_RUN) |-> wake_cnt_q >= `PMCC_WAKE_CLKS && !int_q)
    else $error("wake ended before two processor clocks");
  idle_clear_a: assert property (@(posedge clock) disable iff (!rst_n)
    (idle_now && !was_idle_q) |=> link_ctrl_clear)
    else $error("link controller not cleared on idle entry");
  oe_sticky_a: assert property (@(posedge clock) disable iff (!rst_n)
    matrix_connected |=> serial_drive_oe [*3])
    else $error("serial outputs not driven after connection");
  data_mode_a: assert property (@(posedge clock) disable iff (!rst_n)
    (st_q == ST_RUN && mode == `PMCC_MODE_ADO) |=> block_enable == `PMCC_EN_DATA)
    else $error("data-only enables wrong");
  pd_refuse_a: assert property (@(posedge clock) disable iff (!rst_n)
    (wr_init && !pd_en) |=> mode != `PMCC_MODE_PD)
    else $error("power-down code stored while disabled");
  int_hold_a: assert property (@(posedge clock) disable iff (!rst_n)
    (int_q && !ir_read) |=> int_q)
    else $error("interrupt dropped without a read");
  wake_idle_a: assert property (@(posedge clock) disable iff (!rst_n)
    wake_go |=> st_q == ST_WAKE && mode == `PMCC_MODE_IDLE)
    else $error("wake event did not leave power-down");
  enter_pd_c: cover property (@(posedge clock) disable iff (!rst_n) st_q == ST_COUNT ##1 st_q == ST_PD);
  wake_run_c: cover property (@(posedge clock) disable iff (!rst_n) st_q == ST_WAKE ##1 st_q == ST_RUN);
  cancel_c: cover property (@(posedge clock) disable iff (!rst_n) cancel);
  osc_pd_c: cover property (@(posedge clock) disable iff (!rst_n) st_q == ST_PD_OSC ##1 st_q == ST_PD);
endmodule // pmcc_top
`default_nettype wire

// [inc/pmcc_defines.svh]
// Constants for the power-mode and processor-clock controller
`ifndef PMCC_DEFINES_SVH
`define PMCC_DEFINES_SVH
// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define PMCC_CLK_PERIOD_NS 10
`define PMCC_INT_PERIOD_NS 125000
`define PMCC_PD_COUNT 8'hFA
`define PMCC_WAKE_CLKS 2'h2
// ----------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------
`define PMCC_OFS_INIT 8'h00
`define PMCC_OFS_SECOND_INIT_REGISTER 8'h04
`define PMCC_OFS_WCFG 8'h08
`define PMCC_OFS_IRQ 8'h0C
`define PMCC_OFS_STAT 8'h10
`define PMCC_REG_RST 8'h00
// ----------------------------------------------------------------
// Fields
// ----------------------------------------------------------------
`define PMCC_INIT_MODE 1:0
`define PMCC_INIT_INTDIS 2
`define PMCC_INIT_CLKSEL 5:3
`define PMCC_SECOND_INIT_REGISTER_PDEN 5
`define PMCC_SECOND_INIT_REGISTER_CLKSEL 2:0
`define PMCC_MODE_IDLE 2'h0
`define PMCC_MODE_AVD 2'h1
`define PMCC_MODE_ADO 2'h2
`define PMCC_MODE_PD 2'h3
`define PMCC_CK2_INIT 3'h0
`define PMCC_CK2_1536 3'h1
`define PMCC_CK2_768 3'h2
`define PMCC_CK2_384 3'h3
`define PMCC_CK2_STOP 3'h4
`define PMCC_CK1_12288 3'h1
`define PMCC_CK1_3072 3'h2
`define PMCC_CK1_4096 3'h4
`define PMCC_WCFG_HOOK 0
`define PMCC_WCFG_F7 1
`define PMCC_WCFG_TREQ 2
`define PMCC_WCFG_MASTER 3
`define PMCC_WCFG_LINE 4
`define PMCC_IRQ_HOOK 0
`define PMCC_IRQ_F7 1
`define PMCC_IRQ_TREQ 2
`define PMCC_IRQ_EXT 3
// Half crystal periods per half output period
`define PMCC_RAT_12288 6'h01
`define PMCC_RAT_6144 6'h02
`define PMCC_RAT_4096 6'h03
`define PMCC_RAT_3072 6'h04
`define PMCC_RAT_1536 6'h08
`define PMCC_RAT_768 6'h10
`define PMCC_RAT_384 6'h20
// ----------------------------------------------------------------
// Block enables: host, line, link, osc, port, matrix, ringer, audio
// ----------------------------------------------------------------
`define PMCC_EN_FULL 8'hFF
`define PMCC_EN_DATA 8'h7F
`define PMCC_EN_IDLE 8'h0B
`define PMCC_EN_PDOSC 8'h0A
`define PMCC_EN_PD 8'h02
`define PMCC_LI_F3 4'h3
`define PMCC_LI_F7 4'h7
// Pin vector: crystal, cs_n, wr_n, hook, serial data, serial clock
`define PMCC_PIN_XTAL 0
`define PMCC_PIN_CS 1
`define PMCC_PIN_WR 2
`define PMCC_PIN_HOOK 3
`define PMCC_PIN_SDI 4
`define PMCC_PIN_SCLK 5
`define PMCC_PIN_RST 6'h1E
`define PMCC_RESP_OKAY 2'h0
`define PMCC_RESP_SLVERR 2'h2
`endif

// [inc/pmcc_pkg.sv]
// Types for the power-mode and processor-clock controller
package pmcc_pkg;
  typedef enum logic [2:0] {
    ST_RUN,
    ST_COUNT,
    ST_PD_OSC,
    ST_PD,
    ST_WAKE
  } pmcc_state_e;
endpackage

// [testbench/pmcc_host_model.sv]
// Host processor model that counts the divided clock and drives its wake select and strobe from the system clock
`timescale 1ns/1ps
`default_nettype none
module pmcc_host_model (
  input wire logic clock,
  input wire logic proc_clk,
  input wire logic wake_req,
  output logic cs_n,
  output logic wr_n,
  output var int rises,
  output var int period_ns
);
  realtime last_t = 0;
  int hold = 0;
  // Both counters are two-state and start at zero, so each has the one driver below
  always @(posedge proc_clk) begin
    rises <= rises + 1;
    period_ns <= int'($realtime - last_t);
    last_t = $realtime;
  end
  // Select and strobe fall together; no data is offered, so none can be stored
  always @(posedge clock) begin
    if (wake_req) hold <= 8;
    else if (hold > 0) hold <= hold - 1;
  end
  assign cs_n = (hold == 0);
  assign wr_n = (hold == 0);
endmodule // pmcc_host_model
`default_nettype wire

// [testbench/power_mode_clock_controller_test.sv]
// Self-checking bench for the power-mode and clock controller
`timescale 1ns/1ps
`default_nettype none
`include "pmcc_defines.svh"
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin err_count++; \
  $display("ERROR %s expected %0h seen %0h", nm, e, g); end end
module power_mode_clock_controller_test;
  logic clock = 0, rst_n = 0, crystal_in = 0, irq_ext = 0, matrix_connected = 0, wake_req = 0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic hook_switch_in = 1, serial_data_in = 1, sclk_in = 0;
  logic [7:0] awaddr = 0, araddr = 0, block_enable;
  logic [31:0] wdata = 0, rdata, rd;
  logic [3:0] wstrb = 4'hF, line_if_state = 4'h3;
  logic [1:0] bresp, rresp, rs, bs;
  logic awready, wready, bvalid, arready, rvalid, crystal_drive_out, proc_clk_out;
  logic host_cs_n, host_wr_n, link_ctrl_clear, serial_drive_oe, int_n;
  int err_count = 0, tests_run = 0, clr_cnt = 0, rises, period_ns, c0;
  logic [1:0] md [3] = '{2'h1, 2'h2, 2'h0};
  logic [7:0] en [3] = '{8'hFF, 8'h7F, 8'h0B};
  logic [2:0] rc [4] = '{3'h1, 3'h2, 3'h4, 3'h0};
  int pr [4] = '{80, 320, 240, 160};
  logic [3:0] wc [4] = '{4'h0, 4'h1, 4'hC, 4'h4};

  always #5 clock = ~clock;
  // Crystal phase kept apart from the system clock
  initial begin
    #3;
    forever #40 crystal_in = ~crystal_in;
  end
  always @(posedge clock) if (link_ctrl_clear === 1'h1) clr_cnt++;

  pmcc_top #(.INT_PERIOD_CYC(50)) uut (.clock, .rst_n, .awaddr, .awvalid, .awready, .wdata, .wstrb,
    .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
    .rready, .crystal_in, .crystal_drive_out, .proc_clk_out, .host_cs_n, .host_wr_n, .hook_switch_in,
    .serial_data_in, .sclk_in, .line_if_state, .irq_ext, .matrix_connected, .block_enable,
    .link_ctrl_clear, .serial_drive_oe, .int_n);
  pmcc_host_model host (.clock, .proc_clk(proc_clk_out), .wake_req, .cs_n(host_cs_n),
    .wr_n(host_wr_n), .rises, .period_ns);

  task automatic results;
    $display("tests %0d errors %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic fail(input string s);
    err_count++;
    $display("ERROR %s expected done seen timeout", s);
    results();
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clock);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    for (n = 0; n < 100; n++) begin
      @(posedge clock);
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
      if (bvalid) break;
    end
    bs = bresp;
    bready <= 1'h0;
    if (n == 100) fail("write");
  endtask

  task automatic rdr(input logic [7:0] a);
    int n;
    @(posedge clock);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    for (n = 0; n < 100; n++) begin
      @(posedge clock);
      if (arready) arvalid <= 1'h0;
      if (rvalid) break;
    end
    rd = rdata;
    rs = rresp;
    rready <= 1'h0;
    if (n == 100) fail("read");
  endtask

  task automatic wen(input logic [7:0] v);
    int n;
    for (n = 0; n < 30000 && block_enable !== v; n++) @(posedge clock);
    `CHK("block_enable", v, block_enable)
    if (n == 30000) fail("block_enable");
  endtask

  task automatic wint;
    int n;
    for (n = 0; n < 300 && int_n !== 1'h0; n++) @(posedge clock);
    if (n == 300) fail("int_n");
  endtask

  initial begin
    repeat (10) @(posedge clock);
    rst_n <= 1'h1;
    @(posedge clock);
    `CHK("block_enable", 8'h0B, block_enable)
    `CHK("serial_drive_oe", 1'h0, serial_drive_oe)
    for (int i = 0; i < 3; i++) begin
      c0 = clr_cnt;
      wr(`PMCC_OFS_INIT, {30'h0, md[i]});
      wen(en[i]);
      repeat (4) @(posedge clock);
    end
    `CHK("link clear", c0 + 1, clr_cnt)
    $display("modes done");
    for (int i = 0; i < 4; i++) begin
      wr(`PMCC_OFS_INIT, {26'h0, rc[i], 3'h0});
      repeat (300) @(posedge clock);
      `CHK("period", pr[i], period_ns)
    end
    wr(`PMCC_OFS_INIT, 32'h3);
    rdr(`PMCC_OFS_INIT);
    `CHK("mode", 2'h0, rd[1:0])
    rdr(8'h40);
    `CHK("rresp", `PMCC_RESP_SLVERR, rs)
    `CHK("rdata", 32'h0, rd)
    wr(8'h40, 32'h0);
    `CHK("bresp", `PMCC_RESP_SLVERR, bs)
    matrix_connected <= 1'h1;
    @(posedge clock);
    matrix_connected <= 1'h0;
    repeat (4) @(posedge clock);
    `CHK("serial_drive_oe", 1'h1, serial_drive_oe)
    $display("rates done");
    wr(`PMCC_OFS_SECOND_INIT_REGISTER, 32'h20);
    wr(`PMCC_OFS_SECOND_INIT_REGISTER, 32'h20);
    `CHK("bresp", `PMCC_RESP_OKAY, bs)
    wr(`PMCC_OFS_INIT, 32'h0B);
    repeat (20) @(posedge clock);
    irq_ext <= 1'h1;
    @(posedge clock);
    irq_ext <= 1'h0;
    wint();
    repeat (10) @(posedge clock);
    rdr(`PMCC_OFS_INIT);
    `CHK("mode", 2'h0, rd[1:0])
    rdr(`PMCC_OFS_IRQ);
    `CHK("irq", 8'h08, rd[7:0])
    repeat (2) @(posedge clock);
    `CHK("int_n", 1'h1, int_n)
    $display("cancel done");
    for (int k = 0; k < 4; k++) begin
      wr(`PMCC_OFS_WCFG, {28'h0, wc[k]});
      c0 = rises;
      wr(`PMCC_OFS_INIT, 32'h0B);
      wen(8'h02);
      `CHK("countdown", 1'h1, rises - c0 >= 250)
      repeat (20) @(posedge clock);
      `CHK("proc clock", 1'h1, proc_clk_out)
      `CHK("crystal drive", 1'h1, crystal_drive_out)
      // Count from the parked clock, so the two wake clocks are inside the window
      c0 = rises;
      if (k == 0) wake_req <= 1'h1;
      if (k == 1) hook_switch_in <= ~hook_switch_in;
      if (k == 2) serial_data_in <= 1'h0;
      if (k == 3) sclk_in <= 1'h1;
      @(posedge clock);
      wake_req <= 1'h0;
      wen(8'h0B);
      serial_data_in <= 1'h1;
      sclk_in <= 1'h0;
      if (k > 0) begin
        wint();
        `CHK("clocks before int", 1'h1, rises - c0 >= 2)
      end
      rdr(`PMCC_OFS_IRQ);
      rdr(`PMCC_OFS_INIT);
      `CHK("init", 8'h08, rd[7:0])
      repeat (100) @(posedge clock);
      `CHK("period", 80, period_ns)
    end
    $display("wakes done");
    wr(`PMCC_OFS_WCFG, 32'h12);
    line_if_state <= 4'h1;
    wr(`PMCC_OFS_INIT, 32'h0B);
    wen(8'h0A);
    line_if_state <= 4'h3;
    wen(8'h02);
    line_if_state <= 4'h7;
    wen(8'h0B);
    // A pending interrupt would cancel the next countdown
    rdr(`PMCC_OFS_IRQ);
    `CHK("irq", 8'h02, rd[7:0])
    line_if_state <= 4'h3;
    wr(`PMCC_OFS_INIT, 32'h0B);
    wen(8'h02);
    rst_n <= 1'h0;
    repeat (10) @(posedge clock);
    rst_n <= 1'h1;
    wen(8'h0B);
    repeat (300) @(posedge clock);
    `CHK("period", 160, period_ns)
    rdr(`PMCC_OFS_STAT);
    `CHK("state", 3'h0, rd[2:0])
    $display("line and reset done");
    results();
  end
endmodule // power_mode_clock_controller_test
`default_nettype wire
